/* src/gcs_pkg.sv */
// package: register map, field layout, timing tables and states of the chop sequencer
package gcs_pkg;

  // clock and modulator period
  localparam int unsigned REF_CLK_HZ    = 10_000_000;
  localparam int unsigned REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
  localparam logic [3:0]  CLK_PER_MOD   = 4'hF;  // modulator period is 16 clocks, counted 0..15

  // register byte addresses
  localparam logic [7:0] ADDR_RATE_CFG = 8'h04;
  localparam logic [7:0] ADDR_CONTROL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_RESULT   = 8'h10;
  localparam logic [7:0] ADDR_COUNT    = 8'h14;

  // data_rate_config fields
  localparam int unsigned RATE_LSB   = 0;
  localparam int unsigned FILTER_BIT = 4;   // 1: sinc3, 0: low latency
  localparam int unsigned MODE_BIT   = 5;   // 1: single shot, 0: continuous
  localparam int unsigned CHOP_BIT   = 7;
  localparam logic [7:0]  RATE_CFG_RST = 8'h04;

  // seq_control fields
  localparam int unsigned CTL_START_BIT = 0;
  localparam int unsigned CTL_DELAY_LSB = 8;
  localparam logic [7:0]  DELAY_RST     = 8'h0E;  // settle delay of 14 modulator periods

  // seq_status fields
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_READY_BIT  = 1;
  localparam int unsigned ST_REV_BIT    = 2;
  localparam int unsigned ST_LINE_BIT   = 3;
  localparam int unsigned ST_PAIR_BIT   = 4;

  // rate indices
  localparam logic [3:0] RATE_MAX_IDX  = 4'hD;   // 4000 SPS
  localparam logic [3:0] RATE_LINE_IDX = 4'h6;   // 60 SPS, highest rate with line rejection

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one settled low-latency conversion, in modulator periods
  localparam logic [19:0] LL_ONE [14] = '{
    20'h19681, 20'h0CE81, 20'h06A81, 20'h03C41, 20'h03881, 20'h01428, 20'h010E9,
    20'h00A28, 20'h00528, 20'h002A8, 20'h00168, 20'h00128, 20'h000A8, 20'h00068};
  // one settled sinc3 conversion (three filter periods)
  localparam logic [19:0] S3_ONE [14] = '{
    20'h4B041, 20'h25841, 20'h12C41, 20'h0B441, 20'h09641, 20'h03C41, 20'h03239,
    20'h01E41, 20'h00F41, 20'h007C1, 20'h00401, 20'h00328, 20'h001A8, 20'h000E8};
  // nominal data period for unchopped continuous results
  localparam logic [19:0] NOM_PER [14] = '{
    20'h19000, 20'h0C800, 20'h06400, 20'h03C00, 20'h03200, 20'h01400, 20'h010A8,
    20'h00A00, 20'h00500, 20'h00280, 20'h00140, 20'h00100, 20'h00080, 20'h00040};

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_CONV  = 2'b10
  } gcs_state_type;

endpackage : gcs_pkg

/* src/gcs_mod_tick.sv */
// modulator period divider: one tick every 16 reference clocks
`timescale 1ns/1ps
`default_nettype none
module gcs_mod_tick (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // tick out
  output var  logic mod_tick
);
  import gcs_pkg::*;

  logic [3:0] div_q;
  logic [3:0] div_d;

  always_comb begin
    div_d = (div_q == CLK_PER_MOD) ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  assign mod_tick = (div_q == CLK_PER_MOD);
endmodule : gcs_mod_tick
`default_nettype wire

/* src/gcs_sequencer.sv */
// chop conversion sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module gcs_sequencer #(
  parameter int unsigned CNT_SHIFT = 0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // conversion triggers
  input  wire logic        start_sync_pin,
  input  wire logic        start_cmd,
  // filter side
  input  wire logic [23:0] filter_data,
  output var  logic        filter_restart,
  output var  logic        input_reversed,
  // results
  output var  logic [23:0] result_data,
  output var  logic        result_valid,
  output var  logic        conv_busy
);
  import gcs_pkg::*;

  // bus state
  logic        aw_have_q, aw_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_have_q, w_have_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  rate_cfg_q, rate_cfg_d, delay_q, delay_d;
  logic        start_wr, rd_result;
  logic [7:0]  aw_word, ar_word;

  // pin synchroniser
  logic        pin_s1_q, pin_s2_q, pin_s3_q;
  logic        pin_lvl_q, pin_lvl_d, pin_rise;

  // sequencer state
  gcs_state_type st_q, st_d;
  logic [19:0] cnt_q, cnt_d;
  logic        pol_q, pol_d;
  logic        have_prev_q, have_prev_d;
  logic [23:0] prev_q, prev_d;
  logic        first_q, first_d;
  logic [23:0] result_q, result_d;
  logic        res_q, res_d, restart_q, restart_d, ready_q, ready_d;
  logic        chop_seen_q, mod_tick;
  logic [15:0] count_q, count_d;

  // decoded configuration
  logic        chop_en, sinc3_sel, single_sel, line_ok, start_evt;
  logic [3:0]  rate_idx;
  logic [19:0] len_raw, len_shift, conv_len;
  logic [24:0] diff;

  gcs_mod_tick u_mod_tick (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .mod_tick (mod_tick)
  );

  assign chop_en    = rate_cfg_q[CHOP_BIT];
  assign sinc3_sel  = rate_cfg_q[FILTER_BIT];
  assign single_sel = rate_cfg_q[MODE_BIT];
  assign rate_idx   = (rate_cfg_q[RATE_LSB +: 4] > RATE_MAX_IDX) ? RATE_MAX_IDX
                                                                 : rate_cfg_q[RATE_LSB +: 4];
  assign line_ok    = (rate_idx <= RATE_LINE_IDX);

  assign aw_word = {aw_addr_q[7:2], 2'b00};
  assign ar_word = {s_axi_araddr[7:2], 2'b00};

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // register bus
  always_comb begin
    aw_have_d  = aw_have_q;
    aw_addr_d  = aw_addr_q;
    w_have_d   = w_have_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    rate_cfg_d = rate_cfg_q;
    delay_d    = delay_q;
    start_wr   = 1'b0;
    rd_result  = 1'b0;
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (aw_word)
        ADDR_RATE_CFG: begin
          if (wstrb_q[0]) begin
            rate_cfg_d = wdata_q[7:0];
          end
        end
        ADDR_CONTROL: begin
          if (wstrb_q[0]) begin
            start_wr = wdata_q[CTL_START_BIT];
          end
          if (wstrb_q[1]) begin
            delay_d = wdata_q[CTL_DELAY_LSB +: 8];
          end
        end
        ADDR_STATUS, ADDR_RESULT, ADDR_COUNT: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (ar_word)
        ADDR_RATE_CFG: rdata_d = {24'h00_0000, rate_cfg_q};
        ADDR_CONTROL:  rdata_d = {16'h0000, delay_q, 8'h00};
        ADDR_STATUS: begin
          rdata_d[ST_BUSY_BIT]  = (st_q != SEQ_IDLE);
          rdata_d[ST_READY_BIT] = ready_q;
          rdata_d[ST_REV_BIT]   = pol_q;
          rdata_d[ST_LINE_BIT]  = line_ok;
          rdata_d[ST_PAIR_BIT]  = have_prev_q;
        end
        ADDR_RESULT: begin
          rdata_d   = {8'h00, result_q};
          rd_result = 1'b1;
        end
        ADDR_COUNT:    rdata_d = {16'h0000, count_q};
        default:       rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // start pin: a change counts once the second and third stages agree
  always_comb begin
    pin_lvl_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_lvl_q;
    pin_rise  = (pin_s2_q == pin_s3_q) && pin_s3_q && !pin_lvl_q;
  end

  // conversion length in modulator periods; each chopped conversion is one fully
  // settled conversion, so a pair doubles it and later pipelined results take one
  always_comb begin
    if (chop_en || first_q) begin
      len_raw = sinc3_sel ? S3_ONE[rate_idx] : LL_ONE[rate_idx];
    end else begin
      len_raw = NOM_PER[rate_idx];
    end
    len_shift = len_raw >> CNT_SHIFT;
    conv_len  = (len_shift == 20'h00000) ? 20'h00001 : len_shift;
  end

  // sign-corrected difference; the reversed sample carries the input negated
  always_comb begin
    if (pol_q) begin
      diff = {prev_q[23], prev_q} - {filter_data[23], filter_data};
    end else begin
      diff = {filter_data[23], filter_data} - {prev_q[23], prev_q};
    end
  end

  assign start_evt = pin_rise || start_cmd || start_wr ||
                     ((st_q != SEQ_IDLE) && (chop_en != chop_seen_q));

  // sequencer
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    pol_d       = pol_q;
    have_prev_d = have_prev_q;
    prev_d      = prev_q;
    first_d     = first_q;
    result_d    = result_q;
    res_d       = 1'b0;
    restart_d   = 1'b0;
    count_d     = count_q;
    if (mod_tick) begin
      cnt_d = cnt_q + 20'h00001;
    end
    case (st_q)
      SEQ_IDLE: cnt_d = 20'h00000;
      SEQ_DELAY: begin
        // chop runs this before every conversion, so the pair sees it twice
        if (cnt_q >= {12'h000, delay_q}) begin
          st_d      = SEQ_CONV;
          cnt_d     = 20'h00000;
          restart_d = 1'b1;
        end
      end
      SEQ_CONV: begin
        if (cnt_q >= conv_len) begin
          cnt_d       = 20'h00000;
          first_d     = 1'b0;
          prev_d      = filter_data;
          have_prev_d = chop_en;
          pol_d       = chop_en ? !pol_q : 1'b0;
          if (chop_en && have_prev_q) begin
            result_d = diff[24:1];
            res_d    = 1'b1;
          end else if (!chop_en) begin
            result_d = filter_data;
            res_d    = 1'b1;
          end
          if (single_sel && (!chop_en || have_prev_q)) begin
            st_d = SEQ_IDLE;
          end else if (chop_en) begin
            st_d = SEQ_DELAY;
          end else begin
            restart_d = 1'b1;
          end
          if (res_d) begin
            count_d = count_q + 16'h0001;
          end
        end
      end
      default: st_d = SEQ_IDLE;
    endcase
    if (start_evt) begin
      st_d        = SEQ_DELAY;
      cnt_d       = 20'h00000;
      pol_d       = 1'b0;
      have_prev_d = 1'b0;
      first_d     = 1'b1;
      res_d       = 1'b0;
      restart_d   = 1'b0;
      result_d    = result_q;
      count_d     = count_q;
    end
    // a new result wins over a clearing read in the same cycle
    ready_d = res_d || (ready_q && !rd_result);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have_q   <= 1'b0;
      aw_addr_q   <= 8'h00;
      w_have_q    <= 1'b0;
      wdata_q     <= 32'h0000_0000;
      wstrb_q     <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      rdata_q     <= 32'h0000_0000;
      rate_cfg_q  <= RATE_CFG_RST;
      delay_q     <= DELAY_RST;
      pin_s1_q    <= 1'b0;
      pin_s2_q    <= 1'b0;
      pin_s3_q    <= 1'b0;
      pin_lvl_q   <= 1'b0;
      st_q        <= SEQ_IDLE;
      cnt_q       <= 20'h00000;
      pol_q       <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q      <= 24'h00_0000;
      first_q     <= 1'b1;
      result_q    <= 24'h00_0000;
      res_q       <= 1'b0;
      restart_q   <= 1'b0;
      ready_q     <= 1'b0;
      chop_seen_q <= 1'b0;
      count_q     <= 16'h0000;
    end else begin
      aw_have_q   <= aw_have_d;
      aw_addr_q   <= aw_addr_d;
      w_have_q    <= w_have_d;
      wdata_q     <= wdata_d;
      wstrb_q     <= wstrb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
      rate_cfg_q  <= rate_cfg_d;
      delay_q     <= delay_d;
      pin_s1_q    <= start_sync_pin;
      pin_s2_q    <= pin_s1_q;
      pin_s3_q    <= pin_s2_q;
      pin_lvl_q   <= pin_lvl_d;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      pol_q       <= pol_d;
      have_prev_q <= have_prev_d;
      prev_q      <= prev_d;
      first_q     <= first_d;
      result_q    <= result_d;
      res_q       <= res_d;
      restart_q   <= restart_d;
      ready_q     <= ready_d;
      chop_seen_q <= chop_en;
      count_q     <= count_d;
    end
  end

  assign filter_restart = restart_q;
  assign input_reversed = pol_q;
  assign result_data    = result_q;
  assign result_valid   = res_q;
  assign conv_busy      = (st_q != SEQ_IDLE);
endmodule : gcs_sequencer
`default_nettype wire

/* verif/gcs_seq_sva.sv */
// checker: port-level assertions for the chop sequencer
`timescale 1ns/1ps
`default_nettype none
module gcs_seq_sva #(
  parameter int unsigned CNT_SHIFT = 0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // sequencer
  input wire logic start_cmd,
  input wire logic filter_restart,
  input wire logic input_reversed,
  input wire logic result_valid,
  input wire logic conv_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_start;
    start_cmd && !conv_busy;
  endsequence
  // settle delay is at least half a modulator period, 8 of its 16 clocks
  sequence s_quiet;
    !filter_restart [*8];
  endsequence

  AST_START_BUSY: assert property (s_start |=> conv_busy)
    else $error("start command left the sequencer idle");
  AST_FIRST_NORMAL: assert property ($rose(conv_busy) |-> !input_reversed)
    else $error("run began with reversed input");
  AST_DELAY_QUIET: assert property ($rose(conv_busy) |-> s_quiet)
    else $error("sampling began before the settle delay");
  AST_POL_HOLD: assert property (filter_restart |=> $stable(input_reversed) [*8])
    else $error("polarity moved inside a conversion");
  AST_RESTART_PULSE: assert property (filter_restart |=> !filter_restart)
    else $error("restart pulse longer than one cycle");
  AST_VALID_PULSE: assert property (result_valid |=> !result_valid)
    else $error("result pulse longer than one cycle");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
endmodule : gcs_seq_sva
`default_nettype wire

/* verif/gcs_filter_model.sv */
// filter model: samples carry a fixed offset that chop must cancel
`timescale 1ns/1ps
`default_nettype none
module gcs_filter_model #(
  parameter logic [23:0] SIG = 24'h012345,
  parameter logic [23:0] OFS = 24'h000400
) (
  input  wire logic        ref_clk,
  input  wire logic        filter_restart,
  input  wire logic        input_reversed,
  output var  logic [23:0] filter_data
);
  initial filter_data = 24'h000000;
  // reversed input flips the signal but not the offset
  always @(posedge ref_clk) begin
    if (filter_restart) filter_data <= input_reversed ? OFS - SIG : SIG + OFS;
  end
endmodule : gcs_filter_model
`default_nettype wire

/* verif/testbench.sv */
// testbench: register table, chop timing, averaging and restart scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gcs_pkg::*;
  localparam int unsigned SH  = 4;
  localparam logic [23:0] SIG = 24'h012345;
  localparam logic [23:0] OFS = 24'h000400;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} gcs_row_type;
  logic        ref_clk, srst, awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
  logic        pin, cmd, frs, rev, resv, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [23:0] fdata, res;
  int          fail_count, checked, d, ll, s3, n;
  logic [31:0] g;
  logic [1:0]  r;
  gcs_row_type rows [6] = '{
    '{8'h04, 32'h000000C5, 32'h000000C5, RESP_OKAY},
    '{8'h08, 32'h00000500, 32'h00000500, RESP_OKAY},
    '{8'h0C, 32'h000000FF, 32'h00000008, RESP_OKAY},
    '{8'h04, 32'h00000007, 32'h00000007, RESP_OKAY},
    '{8'h0C, 32'h00000000, 32'h00000000, RESP_OKAY},
    '{8'h18, 32'h00000001, 32'h00000000, RESP_SLVERR}};

  gcs_sequencer #(.CNT_SHIFT(SH)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .start_sync_pin(pin), .start_cmd(cmd), .filter_data(fdata),
    .filter_restart(frs), .input_reversed(rev), .result_data(res), .result_valid(resv),
    .conv_busy(busy));
  gcs_filter_model #(.SIG(SIG), .OFS(OFS)) u_filt (.ref_clk(ref_clk),
    .filter_restart(frs), .input_reversed(rev), .filter_data(fdata));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic stall();
    fail_count++;
    give_verdict();
  endtask : stall

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // phase of the free-running tick makes durations vary by a modulator period or two
  task automatic chk_rng(input int got, input int exp);
    checked++;
    if (got < exp - 40 || got > exp + 40) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rng

  task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr <= a;
    wdata  <= dat;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge ref_clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    stall();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge ref_clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) begin
        dat = rdata;
        rs  = rresp;
        rready <= 1'b0;
        return;
      end
    end
    stall();
  endtask : axr

  task automatic wait_res(output int cyc);
    for (cyc = 1; cyc < 5000; cyc++) begin
      @(posedge ref_clk);
      #1;
      if (resv === 1'b1) return;
    end
    stall();
  endtask : wait_res

  task automatic pulse_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    d = 14;
  endtask : pulse_reset

  task automatic run(input logic [7:0] cfg, input bit pin_go, input int nres,
                     input logic [23:0] ev, input int t1, input int t2);
    axw(ADDR_RATE_CFG, {24'h0, cfg}, r);
    @(posedge ref_clk);
    if (pin_go) pin <= 1'b1;
    else cmd <= 1'b1;
    @(posedge ref_clk);
    cmd <= 1'b0;
    // the pin filter wants the level to stand in two stages; the run starts as it drops
    if (pin_go) repeat (3) @(posedge ref_clk);
    pin <= 1'b0;
    for (int i = 0; i < nres; i++) begin
      wait_res(n);
      chk_rng(n, (i == 0) ? t1 : t2);
      chk({8'h0, res}, {8'h0, ev});
    end
  endtask : run

  initial begin
    {awv, wv, bready, arv, rready, pin, cmd} = '0;
    {awaddr, araddr, wdata} = '0;
    fail_count = 0;
    checked = 0;
    ll = int'(LL_ONE[13] >> SH);
    s3 = int'(S3_ONE[13] >> SH);
    srst = 1'b1;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    axr(ADDR_RATE_CFG, g, r);
    chk(g, {24'h0, RATE_CFG_RST});
    axr(ADDR_CONTROL, g, r);
    chk(g, {16'h0, DELAY_RST, 8'h0});
    $display("test reset done");
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, r);
      chk({30'h0, r}, {30'h0, rows[i].r});
      axr(rows[i].a, g, r);
      chk(g, rows[i].e);
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    $display("test register table done");
    d = 5;
    run(8'h8D, 1'b0, 3, SIG, 2 * (d + ll) * 16, (d + ll) * 16);
    @(posedge ref_clk);
    cmd <= 1'b1;
    @(posedge ref_clk);
    cmd <= 1'b0;
    wait_res(n);
    chk_rng(n, 2 * (d + ll) * 16);
    $display("test continuous chop and restart done");
    pulse_reset();
    run(8'h9D, 1'b0, 1, SIG, 2 * (d + s3) * 16, 0);
    axw(ADDR_RATE_CFG, 32'h0000001D, r);
    wait_res(n);
    chk_rng(n, (d + s3) * 16);
    chk({8'h0, res}, {8'h0, SIG + OFS});
    $display("test sinc3 chop done");
    pulse_reset();
    run(8'hAD, 1'b1, 1, SIG, 2 * (d + ll) * 16, 0);
    repeat (600) @(posedge ref_clk);
    chk({31'h0, busy}, 32'h0);
    axr(ADDR_STATUS, g, r);
    chk(g, 32'h00000012);
    axr(ADDR_RESULT, g, r);
    chk(g, {8'h0, SIG});
    axr(ADDR_STATUS, g, r);
    chk(g, 32'h00000010);
    axr(ADDR_COUNT, g, r);
    chk(g, 32'h00000001);
    $display("test single shot chop done");
    pulse_reset();
    run(8'h0D, 1'b0, 2, SIG + OFS, (d + ll) * 16, int'(NOM_PER[13] >> SH) * 16);
    chk({31'h0, rev}, 32'h0);
    $display("test chop off done");
    give_verdict();
  end
endmodule : testbench

bind gcs_sequencer gcs_seq_sva #(.CNT_SHIFT(CNT_SHIFT)) u_sva (.ref_clk(ref_clk),
  .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .start_cmd(start_cmd),
  .filter_restart(filter_restart), .input_reversed(input_reversed),
  .result_valid(result_valid), .conv_busy(conv_busy));
`default_nettype wire
